// ==== logic/ciwm_consts.svh ====
// constants of the cyclic io word mapper: parameter numbers, limits, resets
`ifndef CIWM_CONSTS_SVH
`define CIWM_CONSTS_SVH

`define CIWM_NUM_IN_SLOT0 14'h0334
`define CIWM_NUM_OUT_SLOT0 14'h0343
`define CIWM_NUM_UPDATE 14'h0351
`define CIWM_SLOT_MAX 16'h270F
`define CIWM_SLOT_RESET 14'h0000
`define CIWM_FIXED_WORDS 5'h04
`define CIWM_SLOTS 12
`define CIWM_RESTART_CYCLES 64

`endif

// ==== logic/ciwm_mapper.sv ====
// cyclic process-data image builder and receiver for the network interface
`timescale 1ns/100ps
`default_nettype none
`include "ciwm_consts.svh"

module ciwm_mapper #(
   parameter int RESTART_CYCLES = `CIWM_RESTART_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   // parameter access from the drive's parameter handler
   input wire ciwm_pkg::ciwm_cfg_req_t i_cfg,
   output logic o_cfg_ack,
   output logic [15:0] o_cfg_rdata,
   // protocol select, from the interface logic on the same clock
   input wire logic i_modbus_tcp,
   // fixed input words supplied by the drive core
   input wire ciwm_pkg::ciwm_fixed_in_t i_fixed,
   // parameter store read for mapped input words
   output logic o_prd_req,
   output logic [13:0] o_prd_num,
   input wire logic i_prd_valid,
   input wire logic [15:0] i_prd_data,
   // parameter store write for mapped output words
   output logic o_pwr_valid,
   output logic [13:0] o_pwr_num,
   output logic [15:0] o_pwr_data,
   // input area stream toward the network
   input wire logic i_cycle_start,
   output logic o_in_valid,
   output logic [15:0] o_in_data,
   output logic o_in_last,
   input wire logic i_in_ready,
   // output area stream from the network
   input wire logic i_out_valid,
   input wire logic [15:0] i_out_data,
   input wire logic i_out_last,
   output logic o_out_ready,
   output ciwm_pkg::ciwm_fixed_out_t o_fixed,
   // status
   output logic o_link_up,
   output logic [4:0] o_in_count,
   output logic [4:0] o_out_count
);

   localparam int NS = `CIWM_SLOTS;

   generate
      if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65535) begin : g_chk
         $error("ciwm_mapper: RESTART_CYCLES out of range");
      end
   endgenerate

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // words in an area: fixed four plus slots before the first zero
   function automatic logic [4:0] area_len(input logic [13:0] m [NS]);
      logic [4:0] n;
      logic stop;
      n = `CIWM_FIXED_WORDS;
      stop = 1'b0;
      for (int k = 0; k < NS; k++) begin
         if (m[k] == 14'h0000) begin
            stop = 1'b1;
         end
         if (!stop) begin
            n = n + 5'h01;
         end
      end
      return n;
   endfunction

   // slot index of a parameter number relative to a base, or none
   function automatic logic slot_hit(input logic [13:0] num,
                                     input logic [13:0] base,
                                     output logic [3:0] idx);
      logic [13:0] d;
      d = num - base;
      idx = d[3:0];
      return (num >= base) && (d < 14'(NS));
   endfunction

   // ------------------------------------------------------------
   // live mapping registers and update control
   // ------------------------------------------------------------
   logic [13:0] in_map_q [NS];
   logic [13:0] out_map_q [NS];
   logic update_q;
   logic restart_done;
   logic [15:0] restart_cnt_q;
   logic restarting_q;

   logic [3:0] in_idx_hit;
   logic [3:0] out_idx_hit;
   logic in_hit;
   logic out_hit;
   logic upd_hit;
   logic wr_legal;

   always_comb begin
      in_hit = slot_hit(i_cfg.num, `CIWM_NUM_IN_SLOT0, in_idx_hit);
      out_hit = slot_hit(i_cfg.num, `CIWM_NUM_OUT_SLOT0, out_idx_hit);
      upd_hit = (i_cfg.num == `CIWM_NUM_UPDATE);
      wr_legal = (i_cfg.wdata <= `CIWM_SLOT_MAX);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int k = 0; k < NS; k++) begin
            in_map_q[k] <= `CIWM_SLOT_RESET;
            out_map_q[k] <= `CIWM_SLOT_RESET;
         end
      end else if (i_cfg.wr && wr_legal) begin
         if (in_hit) begin
            in_map_q[in_idx_hit] <= i_cfg.wdata[13:0];
         end
         if (out_hit) begin
            out_map_q[out_idx_hit] <= i_cfg.wdata[13:0];
         end
      end
   end

   // writing 1 arms the update; a new 1 in the clearing cycle wins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         update_q <= 1'b0;
      end else if (i_cfg.wr && upd_hit && i_cfg.wdata == 16'h0001) begin
         update_q <= 1'b1;
      end else if (restart_done) begin
         update_q <= 1'b0;
      end
   end

   // restart sequence: link drops for RESTART_CYCLES - 1 cycles, then shadow loads;
   // reset itself runs one so power-up latches the stored mapping
   assign restart_done = restarting_q && (restart_cnt_q == 16'h0000);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         restarting_q <= 1'b1;
         restart_cnt_q <= 16'(RESTART_CYCLES - 1);
      end else if (restart_done) begin
         restarting_q <= 1'b0;
      end else if (restarting_q) begin
         restart_cnt_q <= restart_cnt_q - 16'h0001;
      end else if (update_q) begin
         restarting_q <= 1'b1;
         restart_cnt_q <= 16'(RESTART_CYCLES - 1);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_link_up <= 1'b0;
      end else begin
         o_link_up <= !restarting_q || restart_done;
      end
   end

   // ------------------------------------------------------------
   // shadow copy used by the exchange
   // ------------------------------------------------------------
   logic [13:0] in_sh_q [NS];
   logic [13:0] out_sh_q [NS];
   logic [4:0] in_cnt_q;
   logic [4:0] out_cnt_q;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int k = 0; k < NS; k++) begin
            in_sh_q[k] <= `CIWM_SLOT_RESET;
            out_sh_q[k] <= `CIWM_SLOT_RESET;
         end
         in_cnt_q <= `CIWM_FIXED_WORDS;
         out_cnt_q <= `CIWM_FIXED_WORDS;
      end else if (restart_done) begin
         in_sh_q <= in_map_q;
         out_sh_q <= out_map_q;
         if (i_modbus_tcp) begin
            // parameters are reached directly; no mapped words at all
            in_cnt_q <= `CIWM_FIXED_WORDS;
            out_cnt_q <= `CIWM_FIXED_WORDS;
         end else begin
            in_cnt_q <= area_len(in_map_q);
            out_cnt_q <= area_len(out_map_q);
         end
      end
   end

   assign o_in_count = in_cnt_q;
   assign o_out_count = out_cnt_q;

   // ------------------------------------------------------------
   // parameter read-back
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= 16'h0000;
      end else begin
         o_cfg_ack <= i_cfg.wr || i_cfg.rd;
         if (!i_cfg.rd) begin
            o_cfg_rdata <= 16'h0000;
         end else if (in_hit) begin
            o_cfg_rdata <= {2'b00, in_map_q[in_idx_hit]};
         end else if (out_hit) begin
            o_cfg_rdata <= {2'b00, out_map_q[out_idx_hit]};
         end else if (upd_hit) begin
            o_cfg_rdata <= {15'h0000, update_q};
         end else begin
            o_cfg_rdata <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // input area builder
   // ------------------------------------------------------------
   ciwm_pkg::ciwm_in_state_t st_q;
   logic [4:0] idx_q;
   logic [3:0] slot_sel;
   logic [15:0] fixed_word;

   assign slot_sel = 4'(idx_q - `CIWM_FIXED_WORDS);

   always_comb begin
      unique case (idx_q[1:0])
         2'h0: fixed_word = i_fixed.status_word;
         2'h1: fixed_word = i_fixed.motor_speed;
         2'h2: fixed_word = i_fixed.torque_current;
         2'h3: fixed_word = i_fixed.control_mode;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= ciwm_pkg::ST_IDLE;
         idx_q <= 5'h00;
         o_prd_req <= 1'b0;
         o_prd_num <= 14'h0000;
         o_in_valid <= 1'b0;
         o_in_data <= 16'h0000;
         o_in_last <= 1'b0;
      end else if (restarting_q) begin
         // a restart abandons any half-built image
         st_q <= ciwm_pkg::ST_IDLE;
         o_prd_req <= 1'b0;
         o_in_valid <= 1'b0;
         o_in_last <= 1'b0;
      end else begin
         o_prd_req <= 1'b0;
         unique case (st_q)
            ciwm_pkg::ST_IDLE: begin
               if (i_cycle_start) begin
                  idx_q <= 5'h00;
                  st_q <= ciwm_pkg::ST_LOAD;
               end
            end
            ciwm_pkg::ST_LOAD: begin
               o_in_last <= (idx_q == in_cnt_q - 5'h01);
               if (idx_q < `CIWM_FIXED_WORDS) begin
                  o_in_data <= fixed_word;
                  o_in_valid <= 1'b1;
                  st_q <= ciwm_pkg::ST_SEND;
               end else begin
                  o_prd_req <= 1'b1;
                  o_prd_num <= in_sh_q[slot_sel];
                  st_q <= ciwm_pkg::ST_WAIT;
               end
            end
            ciwm_pkg::ST_WAIT: begin
               if (i_prd_valid) begin
                  // raw integer, no scaling applied
                  o_in_data <= i_prd_data;
                  o_in_valid <= 1'b1;
                  st_q <= ciwm_pkg::ST_SEND;
               end
            end
            ciwm_pkg::ST_SEND: begin
               if (i_in_ready) begin
                  o_in_valid <= 1'b0;
                  if (o_in_last) begin
                     o_in_last <= 1'b0;
                     st_q <= ciwm_pkg::ST_IDLE;
                  end else begin
                     idx_q <= idx_q + 5'h01;
                     st_q <= ciwm_pkg::ST_LOAD;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // output area receiver
   // ------------------------------------------------------------
   logic [4:0] oidx_q;
   logic [3:0] oslot;
   logic take;

   assign take = i_out_valid && o_out_ready;
   assign oslot = 4'(oidx_q - `CIWM_FIXED_WORDS);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_out_ready <= 1'b0;
      end else begin
         o_out_ready <= !restarting_q || restart_done;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         oidx_q <= 5'h00;
      end else if (restarting_q) begin
         oidx_q <= 5'h00;
      end else if (take) begin
         if (i_out_last) begin
            oidx_q <= 5'h00;
         end else if (oidx_q != 5'h1F) begin
            oidx_q <= oidx_q + 5'h01;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fixed <= '0;
      end else if (take) begin
         unique case (oidx_q)
            5'h00: o_fixed.control_word <= i_out_data;
            5'h01: o_fixed.speed_ref <= i_out_data;
            5'h02: o_fixed.torque_ref <= i_out_data;
            5'h03: o_fixed.mode_req <= i_out_data;
            default: ;
         endcase
      end
   end

   // words past the configured length are dropped without complaint
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pwr_valid <= 1'b0;
         o_pwr_num <= 14'h0000;
         o_pwr_data <= 16'h0000;
      end else begin
         o_pwr_valid <= 1'b0;
         if (take && oidx_q >= `CIWM_FIXED_WORDS
             && oidx_q < out_cnt_q) begin
            o_pwr_valid <= 1'b1;
            o_pwr_num <= out_sh_q[oslot];
            o_pwr_data <= i_out_data;
         end
      end
   end

endmodule
`default_nettype wire

// ==== logic/ciwm_pkg.sv ====
// types of the cyclic io word mapper
`default_nettype none
package ciwm_pkg;

   typedef struct packed {
      logic [15:0] status_word;
      logic [15:0] motor_speed;
      logic [15:0] torque_current;
      logic [15:0] control_mode;
   } ciwm_fixed_in_t;

   typedef struct packed {
      logic [15:0] control_word;
      logic [15:0] speed_ref;
      logic [15:0] torque_ref;
      logic [15:0] mode_req;
   } ciwm_fixed_out_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [13:0] num;
      logic [15:0] wdata;
   } ciwm_cfg_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_WAIT,
      ST_SEND
   } ciwm_in_state_t;

endpackage
`default_nettype wire

// ==== verification/ciwm_mapper_monitor.sv ====
// port checker of the cyclic io word mapper
`timescale 1ns/100ps
`default_nettype none
module ciwm_mapper_monitor #(
   parameter int RESTART_CYCLES = 64
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire ciwm_pkg::ciwm_cfg_req_t i_cfg,
   input wire logic o_cfg_ack,
   input wire ciwm_pkg::ciwm_fixed_in_t i_fixed,
   input wire logic i_prd_valid,
   input wire logic o_in_valid,
   input wire logic [15:0] o_in_data,
   input wire logic o_in_last,
   input wire logic i_in_ready,
   input wire logic i_out_valid,
   input wire logic [15:0] i_out_data,
   input wire logic i_out_last,
   input wire logic o_out_ready,
   input wire ciwm_pkg::ciwm_fixed_out_t o_fixed,
   input wire logic o_pwr_valid,
   input wire logic [15:0] o_pwr_data,
   input wire logic o_link_up,
   input wire logic [4:0] o_in_count,
   input wire logic [4:0] o_out_count
);
   // longest wait, after the link drops, for it to come back
   localparam int RESTART_MAX = RESTART_CYCLES + 1;
   // ------------------
   // word position trackers
   // ------------------
   logic [4:0] in_idx_q;
   logic [4:0] out_idx_q;
   wire logic in_acc = o_in_valid && i_in_ready;
   wire logic out_acc = i_out_valid && o_out_ready;
   // a restart aborts any area in flight, so both trackers restart too
   always_ff @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n) in_idx_q <= '0;
      else if (!o_link_up || (in_acc && o_in_last)) in_idx_q <= '0;
      else if (in_acc) in_idx_q <= in_idx_q + 5'h01;
   always_ff @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n) out_idx_q <= '0;
      else if (!o_link_up || (out_acc && i_out_last)) out_idx_q <= '0;
      else if (out_acc) out_idx_q <= out_idx_q + 5'h01;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_upd;
      i_cfg.wr && i_cfg.num == 14'h0351 && i_cfg.wdata == 16'h0001;
   endsequence
   sequence s_restart;
      !o_link_up ##[1:RESTART_MAX] o_link_up;
   endsequence
   // update flag, then restart start, then link low: seen three edges on
   property p_restart; s_upd |-> ##3 s_restart; endproperty
   property p_ack; (i_cfg.wr || i_cfg.rd) |=> o_cfg_ack; endproperty
   property p_noack; !(i_cfg.wr || i_cfg.rd) |=> !o_cfg_ack; endproperty
   property p_fixed_in;
      o_in_valid && in_idx_q < 5'h04 |->
         o_in_data == i_fixed[(3 - in_idx_q[1:0]) * 16 +: 16];
   endproperty
   property p_last;
      o_in_valid |-> o_in_last == (in_idx_q == o_in_count - 5'h01);
   endproperty
   property p_hold;
      o_in_valid && !i_in_ready |=>
         o_in_valid && $stable(o_in_data) && $stable(o_in_last);
   endproperty
   property p_prd; i_prd_valid |=> o_in_valid; endproperty
   property p_ctl;
      out_acc && out_idx_q == 5'h00 |=>
         o_fixed.control_word == $past(i_out_data);
   endproperty
   property p_pwr;
      out_acc && out_idx_q >= 5'h04 && out_idx_q < o_out_count |=>
         o_pwr_valid && o_pwr_data == $past(i_out_data);
   endproperty
   property p_drop; out_acc && out_idx_q >= o_out_count |=> !o_pwr_valid;
   endproperty
   property p_counts;
      o_link_up && $past(o_link_up) |->
         $stable(o_in_count) && $stable(o_out_count);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   a_ack: assert property (p_ack) else $error("ack missing");
   a_noack: assert property (p_noack) else $error("stray ack");
   a_fixed_in: assert property (p_fixed_in) else $error("fixed word");
   a_last: assert property (p_last) else $error("area length");
   a_hold: assert property (p_hold) else $error("word not held");
   a_prd: assert property (p_prd) else $error("mapped word late");
   a_ctl: assert property (p_ctl) else $error("control word");
   a_pwr: assert property (p_pwr) else $error("mapped write");
   a_drop: assert property (p_drop) else $error("extra write");
   a_counts: assert property (p_counts) else $error("counts moved");
endmodule
bind ciwm_mapper ciwm_mapper_monitor #(.RESTART_CYCLES(RESTART_CYCLES)) u_mon (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg(i_cfg),
   .o_cfg_ack(o_cfg_ack), .i_fixed(i_fixed), .i_prd_valid(i_prd_valid),
   .o_in_valid(o_in_valid), .o_in_data(o_in_data), .o_in_last(o_in_last),
   .i_in_ready(i_in_ready), .i_out_valid(i_out_valid),
   .i_out_data(i_out_data), .i_out_last(i_out_last),
   .o_out_ready(o_out_ready), .o_fixed(o_fixed), .o_pwr_valid(o_pwr_valid),
   .o_pwr_data(o_pwr_data), .o_link_up(o_link_up),
   .o_in_count(o_in_count), .o_out_count(o_out_count));
`default_nettype wire

// ==== verification/ciwm_mapper_tb.sv ====
// self-checking bench of the cyclic io word mapper
`timescale 1ns/100ps
`default_nettype none
`include "ciwm_consts.svh"
module ciwm_mapper_tb;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   ciwm_pkg::ciwm_cfg_req_t i_cfg = '0;
   ciwm_pkg::ciwm_fixed_in_t i_fixed = '0;
   ciwm_pkg::ciwm_fixed_out_t o_fixed;
   logic i_modbus_tcp = 1'b0;
   logic i_prd_valid = 1'b0;
   logic i_cycle_start = 1'b0;
   logic i_stall = 1'b0;
   logic [15:0] i_prd_data = '0;
   logic o_cfg_ack, o_prd_req, o_pwr_valid, o_in_valid, o_in_last;
   logic i_in_ready, i_out_valid, i_out_last, o_out_ready, o_link_up;
   logic [15:0] o_cfg_rdata, o_pwr_data, o_in_data, i_out_data;
   logic [13:0] o_prd_num, o_pwr_num;
   logic [4:0] o_in_count, o_out_count;
   logic mst_timeout;
   int failures = 0;
   int n_tests = 0;
   logic [15:0] qi[$];
   logic [29:0] qp[$];
   logic [16:0] qc[$];
   logic [16:0] ce;
   logic [15:0] ow [0:15];
   logic [13:0] mp [0:11];
   always #12.5 i_clk = ~i_clk;
   ciwm_mapper #(.RESTART_CYCLES(4)) dut (.i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_cfg(i_cfg), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
      .i_modbus_tcp(i_modbus_tcp), .i_fixed(i_fixed), .o_prd_req(o_prd_req),
      .o_prd_num(o_prd_num), .i_prd_valid(i_prd_valid),
      .i_prd_data(i_prd_data), .o_pwr_valid(o_pwr_valid),
      .o_pwr_num(o_pwr_num), .o_pwr_data(o_pwr_data),
      .i_cycle_start(i_cycle_start), .o_in_valid(o_in_valid),
      .o_in_data(o_in_data), .o_in_last(o_in_last), .i_in_ready(i_in_ready),
      .i_out_valid(i_out_valid), .i_out_data(i_out_data),
      .i_out_last(i_out_last), .o_out_ready(o_out_ready), .o_fixed(o_fixed),
      .o_link_up(o_link_up), .o_in_count(o_in_count),
      .o_out_count(o_out_count));
   ciwm_master_model u_mst (.i_clk(i_clk), .i_stall(i_stall),
      .i_accept(o_out_ready), .o_ready(i_in_ready), .o_valid(i_out_valid),
      .o_data(i_out_data), .o_last(i_out_last), .o_timeout(mst_timeout));
   // ------------------
   // helpers
   // ------------------
   function automatic logic [15:0] pv(input logic [13:0] n);
      return {n, 2'b01} ^ 16'hA5C3;
   endfunction
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task give_verdict;
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cfg(input logic wr, input logic [13:0] n, input logic [15:0] d);
      @(posedge i_clk);
      #2 i_cfg = {wr, !wr, n, d};
      qc.push_back({!wr, d});
      @(posedge i_clk);
      #2 i_cfg = '0;
   endtask
   task wait_up;
      int k;
      k = 0;
      repeat (3) @(posedge i_clk);
      while (!o_link_up && k < 100) begin
         @(posedge i_clk);
         k++;
      end
      if (!o_link_up) begin
         failures++;
         give_verdict;
      end
      #2;
   endtask
   task image(input int n);
      int k;
      @(posedge i_clk);
      #2 i_fixed = {$urandom, $urandom};
      for (k = 0; k < 4; k++) qi.push_back(i_fixed[63 - 16 * k -: 16]);
      for (k = 0; k < n; k++) qi.push_back(pv(mp[k]));
      i_cycle_start = 1'b1;
      @(posedge i_clk);
      #2 i_cycle_start = 1'b0;
      k = 0;
      while (qi.size() > 0 && k < 400) begin
         @(posedge i_clk);
         k++;
      end
      if (qi.size() > 0) begin
         failures++;
         give_verdict;
      end
      repeat (2) @(posedge i_clk);
   endtask
   // parameter store, answers after a random wait
   always @(posedge i_clk) if (o_prd_req) begin
      repeat ($urandom_range(2)) @(posedge i_clk);
      #2 i_prd_valid = 1'b1;
      i_prd_data = pv(o_prd_num);
      @(posedge i_clk);
      #2 i_prd_valid = 1'b0;
      i_prd_data = ~i_prd_data;
   end
   // result watcher: oldest note against each result
   always @(posedge i_clk) begin
      if (mst_timeout) begin
         failures++;
         give_verdict;
      end
      if (o_in_valid && i_in_ready)
         chk(o_in_data, qi.size() ? qi.pop_front() : 'x);
      if (o_pwr_valid)
         chk({o_pwr_num, o_pwr_data}, qp.size() ? qp.pop_front() : 'x);
      if (o_cfg_ack) begin
         ce = qc.size() ? qc.pop_front() : 'x;
         if (ce[16] !== 1'b0) chk(o_cfg_rdata, ce[15:0]);
      end
   end
   initial begin
      void'($urandom(25201));
      repeat (2) @(posedge i_clk);
      #2 i_reset_n = 1'b1;
      wait_up;
      for (int k = 0; k < 12; k++) begin
         cfg(0, 14'(`CIWM_NUM_IN_SLOT0 + k), 16'h0000);
         cfg(0, 14'(`CIWM_NUM_OUT_SLOT0 + k), 16'h0000);
      end
      cfg(0, `CIWM_NUM_UPDATE, 16'h0000);
      image(0);
      mp = '{0: 14'h0003, 1: 14'h0069, 2: 14'($urandom_range(9998, 1)),
         3: 14'h270F, 5: 14'h0007, default: 14'h0000};
      for (int k = 0; k < 12; k++)
         cfg(1, 14'(`CIWM_NUM_IN_SLOT0 + k), 16'(mp[k]));
      cfg(1, `CIWM_NUM_IN_SLOT0, 16'h2710);
      cfg(0, `CIWM_NUM_IN_SLOT0, 16'h0003);
      cfg(0, 14'(`CIWM_NUM_IN_SLOT0 + 3), 16'h270F);
      cfg(1, `CIWM_NUM_OUT_SLOT0, 16'h0069);
      cfg(1, 14'(`CIWM_NUM_OUT_SLOT0 + 1), 16'h012C);
      cfg(1, 14'(`CIWM_NUM_OUT_SLOT0 + 3), 16'h000C);
      image(0);
      i_stall = 1'b1;
      cfg(1, `CIWM_NUM_UPDATE, 16'h0001);
      wait_up;
      cfg(0, `CIWM_NUM_UPDATE, 16'h0000);
      chk(o_in_count, 5'h08);
      chk(o_out_count, 5'h06);
      image(4);
      for (int k = 0; k < 7; k++) ow[k] = 16'($urandom);
      qp.push_back({14'h0069, ow[4]});
      qp.push_back({14'h012C, ow[5]});
      @(posedge i_clk);
      u_mst.send(7, ow);
      chk(o_fixed, {ow[0], ow[1], ow[2], ow[3]});
      repeat (3) @(posedge i_clk);
      chk(qp.size(), 0);
      #2 i_modbus_tcp = 1'b1;
      cfg(1, `CIWM_NUM_UPDATE, 16'h0001);
      wait_up;
      chk({o_in_count, o_out_count}, 10'h084);
      image(0);
      @(posedge i_clk);
      u_mst.send(7, ow);
      repeat (3) @(posedge i_clk);
      give_verdict;
   end
endmodule
`default_nettype wire

// ==== verification/ciwm_master_model.sv ====
// network master model: takes the input area, sends the output area
`timescale 1ns/100ps
`default_nettype none
module ciwm_master_model (
   input wire logic i_clk,
   input wire logic i_stall,
   input wire logic i_accept,
   output logic o_ready,
   output logic o_valid,
   output logic [15:0] o_data,
   output logic o_last,
   output logic o_timeout
);
   // ------------------
   // stream ends
   // ------------------
   initial begin
      o_ready = 1'b1;
      o_valid = 1'b0;
      o_data = '0;
      o_last = 1'b0;
      o_timeout = 1'b0;
   end
   always @(posedge i_clk) begin
      #2 o_ready = !i_stall || ($urandom_range(1) == 1);
   end
   // idle data is inverted so a stale word never looks valid
   task send(input int n, input logic [15:0] w [0:15]);
      int t;
      for (int k = 0; k < n; k++) begin
         #2 o_valid = 1'b1;
         o_data = w[k];
         o_last = (k == n - 1);
         t = 0;
         do begin
            @(posedge i_clk);
            t++;
         end while (!i_accept && t < 50);
         // a word never taken is reported to the bench as a failure
         if (!i_accept) o_timeout = 1'b1;
      end
      #2 o_valid = 1'b0;
      o_data = ~o_data;
      o_last = 1'b0;
   endtask
endmodule
`default_nettype wire
